//--- dv/icc_pin_source.sv
/*
  Far-side stand-in: drives the capture pin and both shared timer counts.
  Assumes the caller starts each pulse just after a rising clock edge.
*/
`timescale 1ns/1ps
module icc_pin_source
(
  input wire logic clk,
  output logic pin,
  output logic [15:0] tmrFirst,
  output logic [15:0] tmrSecond
);
  initial
  begin
    pin = 1'b0;
    tmrFirst = 16'h0000;
    tmrSecond = 16'h0000;
  end

  // Timers held still around each edge, so the stored count is known
  task automatic pulse(input logic [7:0] k);
    @(posedge clk);
    pin <= 1'b1;
    tmrFirst <= {8'h10, k};
    tmrSecond <= {8'h20, k};
    repeat (6) @(posedge clk);
    pin <= 1'b0;
    tmrFirst <= {8'h30, k};
    tmrSecond <= {8'h40, k};
    repeat (6) @(posedge clk);
  endtask
endmodule

//--- dv/tb_top.sv
/*
  Self-checking bench for the input capture channel.
  Assumes the channel package and the pin source model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import icc_pkg::*;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [1:0] pwr;
    logic [4:0] np;
    logic [2:0] cnt;
    logic [15:0] first;
    logic ov;
    logic [3:0] ev;
    logic [1:0] wk;
  } icc_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic capPin;
  logic [15:0] tmrA;
  logic [15:0] tmrB;
  icc_power_t pwr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, captureEvent, wakeRequest, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  int failures = 0;
  int num_checks = 0;
  int evCnt = 0;
  int wkCnt = 0;
  // Control, power, pulses, buffered count, first value, overflow, events (F skips), wakes
  icc_row_t rows [16] = '{
    '{16'h0083, 2'h0, 5'h04, 3'h4, 16'h1000, 1'b0, 4'h4, 2'h0},
    '{16'h0002, 2'h0, 5'h04, 3'h4, 16'h4000, 1'b0, 4'h4, 2'h0},
    '{16'h00E1, 2'h0, 5'h02, 3'h4, 16'h1000, 1'b0, 4'h4, 2'h0},
    '{16'h0004, 2'h0, 5'h04, 3'h1, 16'h2003, 1'b0, 4'h1, 2'h0},
    '{16'h0005, 2'h0, 5'h10, 3'h1, 16'h200F, 1'b0, 4'h1, 2'h0},
    '{16'h0080, 2'h0, 5'h04, 3'h0, 16'h0000, 1'b0, 4'h0, 2'h0},
    '{16'h0086, 2'h0, 5'h04, 3'h0, 16'h0000, 1'b0, 4'h0, 2'h0},
    '{16'h0007, 2'h2, 5'h02, 3'h0, 16'h0000, 1'b0, 4'hF, 2'h2},
    '{16'h0007, 2'h1, 5'h02, 3'h0, 16'h0000, 1'b0, 4'hF, 2'h2},
    '{16'h0007, 2'h0, 5'h02, 3'h0, 16'h0000, 1'b0, 4'hF, 2'h0},
    '{16'h00E3, 2'h0, 5'h04, 3'h4, 16'h1000, 1'b0, 4'h1, 2'h0},
    '{16'h0023, 2'h0, 5'h03, 3'h3, 16'h2000, 1'b0, 4'h1, 2'h0},
    '{16'h0043, 2'h0, 5'h03, 3'h3, 16'h2000, 1'b0, 4'h1, 2'h0},
    '{16'h2083, 2'h1, 5'h04, 3'h0, 16'h0000, 1'b0, 4'h0, 2'h0},
    '{16'h0083, 2'h1, 5'h04, 3'h4, 16'h1000, 1'b0, 4'h4, 2'h0},
    '{16'h0083, 2'h0, 5'h05, 3'h4, 16'h1000, 1'b1, 4'hF, 2'h0}
  };

  always #5 clk = ~clk;

  // Pulses are combinational, so count them away from the sampling edge
  always @(negedge clk)
  begin
    if (captureEvent === 1'b1) evCnt++;
    if (wakeRequest === 1'b1) wkCnt++;
  end

  icc_pin_source u_src (.clk(clk), .pin(capPin), .tmrFirst(tmrA), .tmrSecond(tmrB));

  icc_input_capture_channel u_dut (
    .clk(clk), .rst(rst), .capture_input_pin(capPin), .first_shared_timer(tmrA),
    .second_shared_timer(tmrB), .powerState(pwr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .captureEvent(captureEvent), .wakeRequest(wakeRequest), .irq(irq)
  );

  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkIrq(input string n, input logic e);
    @(negedge clk);
    num_checks++;
    if (irq !== e)
    begin
      failures++;
      $display("ERROR %s expected %b seen %b", n, e, irq);
    end
    // Bus tasks after this one must start right after a rising edge
    @(posedge clk);
  endtask

  // Handshakes judged at the falling edge, acted on at the next rising edge
  task automatic axiW(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta;
    logic tw;
    logic got;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    n = 0;
    got = 1'b0;
    while (!got && n < 50)
    begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      got = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    @(posedge clk);
    if (!got)
    begin
      failures++;
      $display("ERROR bvalid expected 1 seen 0");
      summarize();
    end
  endtask

  task automatic axiR(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta;
    logic got;
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    n = 0;
    got = 1'b0;
    while (!got && n < 50)
    begin
      @(negedge clk);
      ta = arvalid && arready;
      got = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    @(posedge clk);
    if (!got)
    begin
      failures++;
      $display("ERROR rvalid expected 1 seen 0");
      summarize();
    end
  endtask

  task automatic runRow(input icc_row_t r);
    int e0;
    int w0;
    logic [15:0] ex;
    axiW(ICC_CTRL_OFS, {16'h0000, r.ctrl}, rsp);
    pwr <= icc_power_t'(r.pwr);
    e0 = evCnt;
    w0 = wkCnt;
    for (int k = 0; k < r.np; k++) u_src.pulse(8'(k));
    pwr <= '0;
    if (r.ev != 4'hF) chk("events", 32'(r.ev), 32'(evCnt - e0));
    chk("wakes", 32'(r.wk), 32'(wkCnt - w0));
    ex = r.ctrl & ICC_CTRL_WMASK;
    ex[ICC_BNE_BIT] = (r.cnt != 3'h0);
    ex[ICC_OV_BIT] = r.ov;
    axiR(ICC_CTRL_OFS, rd, rsp);
    chk("ctrl status", {16'h0000, ex}, rd);
    for (int k = 0; k < r.cnt; k++)
    begin
      axiR(ICC_BUF_OFS, rd, rsp);
      if (k == 0) chk("oldest value", {16'h0000, r.first}, rd);
    end
    axiR(ICC_CTRL_OFS, rd, rsp);
    chk("drained", {16'h0000, r.ctrl & ICC_CTRL_WMASK}, rd);
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axiR(ICC_CTRL_OFS, rd, rsp);
    chk("ctrl reset", {16'h0000, ICC_CTRL_RESET}, rd);
    axiR(ICC_IRQMASK_OFS, rd, rsp);
    chk("mask reset", 32'h00000000, rd);
    $display("reset values done");
    for (int i = 0; i < 16; i++)
    begin
      runRow(rows[i]);
      $display("row %0d done", i);
    end
    axiR(ICC_IRQSTAT_OFS, rd, rsp);
    chk("irq status", 32'h00000007, rd);
    axiR(ICC_IRQSTAT_OFS, rd, rsp);
    chk("irq status cleared", 32'h00000000, rd);
    // Read-only flags and a write to the buffer must not stick
    axiW(ICC_CTRL_OFS, 32'h0000FFFF, rsp);
    axiW(ICC_BUF_OFS, 32'h00001234, rsp);
    chk("buf write resp", {30'h0, ICC_RESP_OKAY}, {30'h0, rsp});
    axiR(ICC_CTRL_OFS, rd, rsp);
    chk("ctrl mask", 32'h000020E7, rd);
    axiW(4'h2, 32'h00000001, rsp);
    chk("unmapped write", {30'h0, ICC_RESP_SLVERR}, {30'h0, rsp});
    axiR(4'h6, rd, rsp);
    chk("unmapped read", {30'h0, ICC_RESP_SLVERR}, {30'h0, rsp});
    chk("unmapped data", 32'h00000000, rd);
    $display("register access done");
    axiW(ICC_IRQMASK_OFS, 32'h00000001, rsp);
    axiW(ICC_CTRL_OFS, 32'h00000083, rsp);
    chkIrq("irq idle", 1'b0);
    u_src.pulse(8'h00);
    chkIrq("irq raised", 1'b1);
    axiR(ICC_IRQSTAT_OFS, rd, rsp);
    chk("irq cause", 32'h00000001, rd);
    chkIrq("irq cleared", 1'b0);
    axiW(ICC_IRQMASK_OFS, 32'h00000000, rsp);
    u_src.pulse(8'h01);
    chkIrq("irq masked", 1'b0);
    axiR(ICC_IRQSTAT_OFS, rd, rsp);
    chk("masked cause", 32'h00000001, rd);
    $display("interrupt done");
    // Second reset in mid-run with values still buffered
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axiR(ICC_CTRL_OFS, rd, rsp);
    chk("ctrl after reset", {16'h0000, ICC_CTRL_RESET}, rd);
    $display("mid-run reset done");
    summarize();
  end
endmodule

//--- rtl/icc_fifo.sv
/*
  Small capture FIFO with registered read data.
  Assumes the caller never pushes when full or pops when empty.
*/
`timescale 1ns/1ps
module icc_fifo
  import icc_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = ICC_FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic push,
  input wire logic [WIDTH-1:0] pushData,
  input wire logic pop,
  input wire logic flush,
  output logic [WIDTH-1:0] popData,
  output logic [$clog2(DEPTH):0] fillLevel
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wrPtr] <= pushData;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      fillLevel <= '0;
      popData <= '0;
    end
    else if (flush)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      fillLevel <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr <= AW'(wrPtr + 1'b1);
      end
      if (pop)
      begin
        popData <= mem[rdPtr];
        rdPtr <= AW'(rdPtr + 1'b1);
      end
      fillLevel <= (AW+1)'(fillLevel + push - pop);
    end
  end
endmodule

//--- rtl/icc_input_capture_channel.sv
/*
  One input capture channel: edge detection, prescaler, timer select,
  four-entry capture FIFO, status flags, interrupt and AXI4-Lite slave.
  Assumes the two shared timers and power-mode levels come from logic on
  clk; the capture pin is asynchronous.
*/
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
// Function
// R01 - On a capture event store the selected 16-bit timer count
// R02 - Mode 011 every rising, 010 every falling, 001 both edges
// R03 - Mode 100 every fourth rising edge, 101 every sixteenth
// R04 - Modes 000 and 110 disable the channel
// R05 - Mode 111 gives rising-edge interrupt only in Sleep or Idle
// R06 - Interrupt after every 1st, 2nd, 3rd or 4th capture
// R07 - Both-edge mode interrupts on every capture, ignoring the count
// R08 - Four-entry FIFO holds captured values for software
// R09 - Bit 3 reads high while the buffer holds unread values
// R10 - Bit 4 flags overflow; only hardware clears it
// R11 - Bit 7 set selects first timer, clear selects second
// R12 - Bit 13 set halts the channel in Idle mode
// R13 - DMA users set the per-interrupt count to 00
// R14 - Capture pin events wake the device from Sleep and Idle
// R15 - Up to eight channels, each picking either shared timer
// R16 - Reading the buffer returns and removes the oldest value
// R17 - Capture with four held sets overflow; read-empty clears it
module icc_input_capture_channel
  import icc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic capture_input_pin,
  input wire logic [15:0] first_shared_timer,
  input wire logic [15:0] second_shared_timer,
  input wire icc_power_t powerState,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [3:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic captureEvent,
  output logic wakeRequest,
  output logic irq
);
  icc_ctrl_t ctrl;
  logic [2:0] irqStatus;
  logic [2:0] irqMask;
  logic pinMeta;
  logic pinSync;
  logic pinLast;
  logic riseEdge;
  logic fallEdge;
  logic [3:0] preCount;
  logic [1:0] cpiCount;
  logic overflowFlag;
  logic captureFire;
  logic capIrqFire;
  logic doPush;
  logic doPop;
  logic halted;
  logic [15:0] selTimer;
  logic [15:0] popData;
  logic [2:0] fillLevel;
  logic bufferNotEmpty;
  logic awHeld;
  logic wHeld;
  logic [3:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wrFire;
  logic rdFire;
  logic rdPending;
  logic [3:0] rdAddr;
  logic rdBufSel;
  logic channelOn;

  // Pin is asynchronous: two flops before any edge logic
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pinMeta <= 1'b0;
      pinSync <= 1'b0;
      pinLast <= 1'b0;
    end
    else
    begin
      pinMeta <= capture_input_pin;
      pinSync <= pinMeta;
      pinLast <= pinSync;
    end
  end

  assign riseEdge = pinSync & ~pinLast;
  assign fallEdge = ~pinSync & pinLast;
  assign halted = ctrl.idleStop & powerState.idleMode; // R12
  assign channelOn = ~halted && ctrl.captureModeSelect != ICC_MODE_OFF
    && ctrl.captureModeSelect != ICC_MODE_UNUSED
    && ctrl.captureModeSelect != ICC_MODE_WAKE; // R04
  assign bufferNotEmpty = fillLevel != 3'h0;

  always_comb
  begin
    captureFire = 1'b0;
    if (channelOn)
    begin
      unique case (ctrl.captureModeSelect)
        ICC_MODE_RISE: captureFire = riseEdge; // R02
        ICC_MODE_FALL: captureFire = fallEdge; // R02
        ICC_MODE_BOTH: captureFire = riseEdge | fallEdge; // R02
        ICC_MODE_PRE4: captureFire = riseEdge && preCount == 4'(ICC_PRE4_COUNT - 1); // R03
        ICC_MODE_PRE16: captureFire = riseEdge && preCount == 4'(ICC_PRE16_COUNT - 1); // R03
        default: captureFire = 1'b0;
      endcase
    end
  end

  // Prescaler counts rising edges, restarts on mode change
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      preCount <= 4'h0;
    end
    else if (!channelOn || wrFire && awAddr == ICC_CTRL_OFS)
    begin
      preCount <= 4'h0;
    end
    else if (riseEdge)
    begin
      preCount <= captureFire ? 4'h0 : 4'(preCount + 1'b1); // R03
    end
  end

  assign selTimer = ctrl.timeBaseSelect ? first_shared_timer : second_shared_timer; // R11 R15
  assign doPush = captureFire && fillLevel < 3'(ICC_FIFO_DEPTH); // R01 R08
  assign doPop = rdFire && rdBufSel && bufferNotEmpty; // R16

  icc_fifo #(.WIDTH(16), .DEPTH(ICC_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .push(doPush),
    .pushData(selTimer),
    .pop(doPop),
    .flush(1'b0),
    .popData(popData),
    .fillLevel(fillLevel)
  );

  // Overflow: new event with buffer full is dropped, cleared on read-empty
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      overflowFlag <= 1'b0;
    end
    else if (captureFire && fillLevel == 3'(ICC_FIFO_DEPTH))
    begin
      overflowFlag <= 1'b1; // R10 R17
    end
    else if (doPop && fillLevel == 3'h1)
    begin
      overflowFlag <= 1'b0; // R17
    end
  end

  // Captures-per-interrupt counter; both-edge mode bypasses it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cpiCount <= 2'h0;
    end
    else if (!channelOn || wrFire && awAddr == ICC_CTRL_OFS)
    begin
      cpiCount <= 2'h0;
    end
    else if (captureFire)
    begin
      cpiCount <= capIrqFire ? 2'h0 : 2'(cpiCount + 1'b1); // R06
    end
  end

  assign capIrqFire = captureFire && (ctrl.captureModeSelect == ICC_MODE_BOTH
    || cpiCount == ctrl.capturesPerInterrupt); // R06 R07 R13
  assign captureEvent = capIrqFire;
  assign wakeRequest = ctrl.captureModeSelect == ICC_MODE_WAKE && riseEdge
    && (powerState.sleepMode || powerState.idleMode); // R05 R14

  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld & ~s_axi_bvalid;
  assign wrFire = awHeld & wHeld & ~s_axi_bvalid;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 4'h0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ICC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (wrFire)
      begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr == ICC_CTRL_OFS || awAddr == ICC_IRQMASK_OFS
          || awAddr == ICC_BUF_OFS || awAddr == ICC_IRQSTAT_OFS)
          ? ICC_RESP_OKAY : ICC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register; flag bits are hardware-owned so the mask drops them
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl <= icc_ctrl_t'({ICC_CTRL_RESET[ICC_SIDL_BIT], ICC_CTRL_RESET[7:5],
        ICC_CTRL_RESET[2:0]});
      irqMask <= ICC_IRQ_RESET;
    end
    else if (wrFire)
    begin
      if (awAddr == ICC_CTRL_OFS)
      begin
        if (wStrb[0])
        begin
          ctrl.timeBaseSelect <= wData[ICC_TSEL_BIT] & ICC_CTRL_WMASK[ICC_TSEL_BIT];
          ctrl.capturesPerInterrupt <= wData[ICC_CPI_LSB +: 2];
          ctrl.captureModeSelect <= icc_mode_t'(wData[ICC_MODE_LSB +: 3]);
        end
        if (wStrb[1])
        begin
          ctrl.idleStop <= wData[ICC_SIDL_BIT];
        end
      end
      else if (awAddr == ICC_IRQMASK_OFS && wStrb[0])
      begin
        irqMask <= wData[2:0];
      end
    end
  end

  // AXI4-Lite read: one outstanding, answer two cycles after address
  assign s_axi_arready = ~rdPending & ~s_axi_rvalid;
  assign rdFire = s_axi_arvalid & s_axi_arready;
  assign rdBufSel = s_axi_araddr == ICC_BUF_OFS;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdPending <= 1'b0;
      rdAddr <= 4'h0;
    end
    else
    begin
      rdPending <= rdFire;
      if (rdFire)
      begin
        rdAddr <= s_axi_araddr;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ICC_RESP_OKAY;
    end
    else if (rdPending)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= ICC_RESP_OKAY;
      unique case (rdAddr)
        ICC_CTRL_OFS: s_axi_rdata <= {16'h0000, 2'h0, ctrl.idleStop, 5'h00,
          ctrl.timeBaseSelect, ctrl.capturesPerInterrupt, overflowFlag,
          bufferNotEmpty, ctrl.captureModeSelect}; // R09 R10
        ICC_BUF_OFS: s_axi_rdata <= {16'h0000, popData}; // R16
        ICC_IRQSTAT_OFS: s_axi_rdata <= {29'h0, irqStatus};
        ICC_IRQMASK_OFS: s_axi_rdata <= {29'h0, irqMask};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= ICC_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Cleared as the read data is latched, so the read still sees the bits
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irqStatus <= ICC_IRQ_RESET;
    end
    else
    begin
      irqStatus <= ((rdPending && rdAddr == ICC_IRQSTAT_OFS) ? 3'h0 : irqStatus)
        | {wakeRequest, captureFire && fillLevel == 3'(ICC_FIFO_DEPTH), capIrqFire};
    end
  end

  assign irq = |(irqStatus & irqMask);

  a_push_timer: assert property (@(posedge clk) disable iff (rst)
    doPush |=> u_fifo.fillLevel != 3'h0) else $error("push lost"); // R01
  a_off_mode: assert property (@(posedge clk) disable iff (rst)
    (ctrl.captureModeSelect inside {ICC_MODE_OFF, ICC_MODE_UNUSED}) |-> !captureFire)
    else $error("capture while off"); // R04
  a_rise_cap: assert property (@(posedge clk) disable iff (rst)
    (channelOn && ctrl.captureModeSelect == ICC_MODE_RISE && riseEdge) |-> captureFire)
    else $error("rise missed"); // R02
  a_fall_cap: assert property (@(posedge clk) disable iff (rst)
    (ctrl.captureModeSelect == ICC_MODE_FALL && captureFire) |-> fallEdge)
    else $error("bad fall capture"); // R02
  a_pre_count: assert property (@(posedge clk) disable iff (rst)
    (ctrl.captureModeSelect == ICC_MODE_PRE4 && captureFire) |-> preCount == 4'h3)
    else $error("prescale off"); // R03
  a_wake_only: assert property (@(posedge clk) disable iff (rst)
    wakeRequest |-> (powerState.sleepMode || powerState.idleMode) && !captureFire)
    else $error("wake misuse"); // R05
  a_fifo_bound: assert property (@(posedge clk) disable iff (rst)
    fillLevel <= 3'(ICC_FIFO_DEPTH)) else $error("fifo overrun"); // R08
  a_ovf_set: assert property (@(posedge clk) disable iff (rst)
    (captureFire && fillLevel == 3'(ICC_FIFO_DEPTH)) |=> overflowFlag)
    else $error("overflow not set"); // R10
  a_idle_halt: assert property (@(posedge clk) disable iff (rst)
    halted |-> !doPush) else $error("capture in idle"); // R12
  a_both_irq: assert property (@(posedge clk) disable iff (rst)
    (ctrl.captureModeSelect == ICC_MODE_BOTH && captureFire) |-> capIrqFire)
    else $error("both-edge irq missed"); // R07

  c_capture: cover property (@(posedge clk) doPush);
  c_overflow: cover property (@(posedge clk) $rose(overflowFlag));
  c_wake: cover property (@(posedge clk) wakeRequest);
  c_irq: cover property (@(posedge clk) $rose(irq));
endmodule

//--- rtl/icc_pkg.sv
/*
  Package for the input capture channel: register offsets, field
  positions, reset values, modes and carrier structs.
  Assumes a 32-bit AXI4-Lite register bus and 16-bit shared timers.
*/
package icc_pkg;
  localparam logic [3:0] ICC_CTRL_OFS = 4'h0;
  localparam logic [3:0] ICC_BUF_OFS = 4'h4;
  localparam logic [3:0] ICC_IRQSTAT_OFS = 4'h8;
  localparam logic [3:0] ICC_IRQMASK_OFS = 4'hC;
  localparam int ICC_MODE_LSB = 0;
  localparam int ICC_BNE_BIT = 3;
  localparam int ICC_OV_BIT = 4;
  localparam int ICC_CPI_LSB = 5;
  localparam int ICC_TSEL_BIT = 7;
  localparam int ICC_SIDL_BIT = 13;
  localparam logic [15:0] ICC_CTRL_RESET = 16'h0000;
  localparam logic [15:0] ICC_CTRL_WMASK = 16'h20E7;
  localparam logic [2:0] ICC_IRQ_RESET = 3'h0;
  localparam int ICC_IRQ_CAP = 0;
  localparam int ICC_IRQ_OVF = 1;
  localparam int ICC_IRQ_WAKE = 2;
  localparam int ICC_FIFO_DEPTH = 4;
  localparam int ICC_PRE4_COUNT = 4;
  localparam int ICC_PRE16_COUNT = 16;
  localparam logic [1:0] ICC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ICC_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ICC_MODE_OFF = 3'h0,
    ICC_MODE_BOTH = 3'h1,
    ICC_MODE_FALL = 3'h2,
    ICC_MODE_RISE = 3'h3,
    ICC_MODE_PRE4 = 3'h4,
    ICC_MODE_PRE16 = 3'h5,
    ICC_MODE_UNUSED = 3'h6,
    ICC_MODE_WAKE = 3'h7
  } icc_mode_t;

  typedef struct packed {
    logic idleStop;
    logic timeBaseSelect;
    logic [1:0] capturesPerInterrupt;
    icc_mode_t captureModeSelect;
  } icc_ctrl_t;

  typedef struct packed {
    logic sleepMode;
    logic idleMode;
  } icc_power_t;
endpackage
